/* File: src/clock_source_ctrl.sv */
// clock source control: boot option, fast oscillator divider, crystal start and system clock switch
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module clock_source_ctrl (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	input  wire logic [7:0]  BOOT_OPTION_I,
	input  wire logic        MAIN_XTAL_TICK_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	output logic             FLASH_HIGH_SPEED_O,
	output logic      [5:0]  FAST_OSC_MHZ_O,
	output logic             FAST_OSC_HALT_O,
	output logic             SUB_OSC_HALT_O,
	output logic             MAIN_OSC_HALT_O,
	output logic             MAIN_OSC_PIN_MODE_O,
	output logic             MAIN_EXT_CLOCK_SEL_O,
	output logic             MAIN_OSC_GAIN_O,
	output logic             CLK_SEL_FAST_O,
	output logic             CLK_SEL_MAIN_O
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0]  boot_clock_option;
	logic        opt_loaded;
	logic [2:0]  fast_osc_divider;
	logic [7:0]  clock_mode_ctrl;
	logic        clock_mode_written;
	logic [2:0]  osc_settle_select;
	logic [7:0]  osc_run_ctrl;
	logic [7:0]  osc_settle_status;
	logic        main_source_select;
	logic        sub_source_select;
	logic        switch_on_main;
	logic        sel_fast;
	logic        sel_main;

	// ----------------------------------------------------------------
	// bus address phase
	// ----------------------------------------------------------------
	logic        wr_pend;
	logic [31:0] wr_addr;
	logic [2:0]  wr_size;

	wire         accept   = HSEL_I && HREADY_I && HTRANS_I[1];
	wire         rd_start = accept && !HWRITE_I;

	wire         rd_boot  = HADDR_I == clock_source_pkg::ADDR_BOOT_OPTION;
	wire         rd_div   = HADDR_I == clock_source_pkg::ADDR_FAST_DIV;
	wire         rd_mode  = HADDR_I == clock_source_pkg::ADDR_CLOCK_MODE;
	wire         rd_sel   = HADDR_I == clock_source_pkg::ADDR_SETTLE_SEL;
	wire         rd_run   = HADDR_I == clock_source_pkg::ADDR_OSC_RUN;
	wire         rd_stat  = HADDR_I == clock_source_pkg::ADDR_SETTLE_STAT;
	wire         rd_sys   = HADDR_I == clock_source_pkg::ADDR_SYS_CLOCK;

	wire  [7:0]  sys_clock_view = {1'b0, sub_source_select, sel_main, main_source_select, 4'h0};

	wire  [7:0]  rd_byte =
		rd_boot ? boot_clock_option :
		rd_div  ? {5'h00, fast_osc_divider} :
		rd_mode ? clock_mode_ctrl :
		rd_sel  ? {5'h00, osc_settle_select} :
		rd_run  ? osc_run_ctrl :
		rd_stat ? osc_settle_status :
		rd_sys  ? sys_clock_view :
		8'h00;

	// ----------------------------------------------------------------
	// bus data phase write decode
	// ----------------------------------------------------------------
	wire         wr_div   = wr_pend && wr_addr == clock_source_pkg::ADDR_FAST_DIV;
	wire         wr_mode  = wr_pend && wr_addr == clock_source_pkg::ADDR_CLOCK_MODE;
	wire         wr_sel   = wr_pend && wr_addr == clock_source_pkg::ADDR_SETTLE_SEL;
	wire         wr_run   = wr_pend && wr_addr == clock_source_pkg::ADDR_OSC_RUN;
	wire         wr_sys   = wr_pend && wr_addr == clock_source_pkg::ADDR_SYS_CLOCK;
	wire         size_ok  = wr_size == clock_source_pkg::HSIZE_BYTE || wr_size == clock_source_pkg::HSIZE_WORD;
	wire  [7:0]  wdata    = HWDATA_I[7:0];

	// ----------------------------------------------------------------
	// frequency and flash mode checks
	// ----------------------------------------------------------------
	wire         freq_top   = boot_clock_option[clock_source_pkg::OPT_FREQ_TOP];
	wire  [1:0]  flash_code = {boot_clock_option[clock_source_pkg::OPT_FLASH_HI],
		boot_clock_option[clock_source_pkg::OPT_FLASH_LO]};
	wire         flash_hs   = flash_code == clock_source_pkg::FLASH_HIGH_SPEED;
	wire  [5:0]  new_mhz    = clock_source_pkg::fast_osc_mhz(freq_top, wdata[2:0]);
	wire         new_in_range = new_mhz != 6'h00 && (flash_hs || new_mhz <= clock_source_pkg::LOW_SPEED_MAX_MHZ);
	wire  [5:0]  cur_mhz    = clock_source_pkg::fast_osc_mhz(freq_top, fast_osc_divider);

	// ----------------------------------------------------------------
	// oscillator state and switch permission
	// ----------------------------------------------------------------
	wire         main_halted  = osc_run_ctrl[clock_source_pkg::CSC_MAIN_HALT];
	wire         fast_halted  = osc_run_ctrl[clock_source_pkg::CSC_FAST_HALT];
	wire         ext_clock    = clock_mode_ctrl[clock_source_pkg::CMC_EXT_CLOCK];
	wire         pin_mode     = clock_mode_ctrl[clock_source_pkg::CMC_PIN_MODE];
	wire         settled      = osc_settle_status[3'h7 - osc_settle_select];
	// an external clock needs no stabilization wait
	wire         main_ok      = pin_mode && !main_halted && (ext_clock || settled);
	wire         fast_ok      = !fast_halted;
	// a running source may not be halted while the cpu still depends on it
	wire         main_halt_ok = !switch_on_main && !main_source_select;
	wire         fast_halt_ok = sel_main;
	wire         next_main_halt = wdata[clock_source_pkg::CSC_MAIN_HALT] && main_halt_ok ? 1'b1 :
		wdata[clock_source_pkg::CSC_MAIN_HALT] ? main_halted : 1'b0;
	wire         next_fast_halt = wdata[clock_source_pkg::CSC_FAST_HALT] && fast_halt_ok ? 1'b1 :
		wdata[clock_source_pkg::CSC_FAST_HALT] ? fast_halted : 1'b0;
	wire  [7:0]  next_run_ctrl = {next_main_halt, wdata[clock_source_pkg::CSC_SUB_HALT], 5'h00, next_fast_halt};

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	// zero wait state: read data is sampled in the address phase
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_pend     <= 1'b0;
			wr_addr     <= 32'h0000_0000;
			wr_size     <= 3'h0;
			HRDATA_O    <= 32'h0000_0000;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end else begin
			wr_pend     <= accept && HWRITE_I;
			wr_addr     <= accept ? HADDR_I : wr_addr;
			wr_size     <= accept ? HSIZE_I : wr_size;
			HRDATA_O    <= rd_start ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// boot option capture and fast oscillator divider
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			boot_clock_option <= 8'h00;
			opt_loaded        <= 1'b0;
			fast_osc_divider  <= clock_source_pkg::RST_FAST_DIV;
		end else if (!opt_loaded) begin
			boot_clock_option <= BOOT_OPTION_I;
			opt_loaded        <= 1'b1;
			fast_osc_divider  <= BOOT_OPTION_I[2:0];
		end else if (wr_div && new_in_range) begin
			fast_osc_divider  <= wdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// clock mode, settle select, run control, system clock
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			clock_mode_ctrl    <= clock_source_pkg::RST_CLOCK_MODE;
			clock_mode_written <= 1'b0;
			osc_settle_select  <= clock_source_pkg::RST_SETTLE_SEL;
			osc_run_ctrl       <= clock_source_pkg::RST_OSC_RUN;
			main_source_select <= 1'b0;
			sub_source_select  <= 1'b0;
		end else begin
			if (wr_mode && size_ok && !clock_mode_written) begin
				clock_mode_ctrl    <= wdata;
				clock_mode_written <= 1'b1;
			end
			if (wr_sel) begin
				osc_settle_select <= wdata[2:0];
			end
			if (wr_run) begin
				osc_run_ctrl <= next_run_ctrl;
			end
			if (wr_sys) begin
				main_source_select <= wdata[4];
				sub_source_select  <= wdata[clock_source_pkg::CKC_SUB_SEL];
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			FLASH_HIGH_SPEED_O   <= 1'b0;
			FAST_OSC_MHZ_O       <= 6'h00;
			FAST_OSC_HALT_O      <= 1'b0;
			SUB_OSC_HALT_O       <= 1'b1;
			MAIN_OSC_HALT_O      <= 1'b1;
			MAIN_OSC_PIN_MODE_O  <= 1'b0;
			MAIN_EXT_CLOCK_SEL_O <= 1'b0;
			MAIN_OSC_GAIN_O      <= 1'b0;
		end else begin
			FLASH_HIGH_SPEED_O   <= flash_hs;
			FAST_OSC_MHZ_O       <= cur_mhz;
			FAST_OSC_HALT_O      <= fast_halted;
			SUB_OSC_HALT_O       <= osc_run_ctrl[clock_source_pkg::CSC_SUB_HALT];
			MAIN_OSC_HALT_O      <= main_halted;
			MAIN_OSC_PIN_MODE_O  <= pin_mode;
			MAIN_EXT_CLOCK_SEL_O <= ext_clock;
			MAIN_OSC_GAIN_O      <= clock_mode_ctrl[clock_source_pkg::CMC_GAIN];
		end
	end

	assign CLK_SEL_FAST_O = sel_fast;
	assign CLK_SEL_MAIN_O = sel_main;

	// ----------------------------------------------------------------
	// sub blocks
	// ----------------------------------------------------------------
	settle_counter #(
		.CNT_W    (clock_source_pkg::SETTLE_CNT_W)
	) u_settle (
		.clk_i    (CORE_CLK_I),
		.rst_n_i  (RST_N_I),
		.run_i    (!main_halted),
		.tick_i   (MAIN_XTAL_TICK_I),
		.status_o (osc_settle_status)
	);

	clock_switch #(
		.GAP         (clock_source_pkg::SWITCH_GAP_CYCLES)
	) u_switch (
		.clk_i       (CORE_CLK_I),
		.rst_n_i     (RST_N_I),
		.want_main_i (main_source_select),
		.main_ok_i   (main_ok),
		.fast_ok_i   (fast_ok),
		.sel_fast_o  (sel_fast),
		.sel_main_o  (sel_main),
		.on_main_o   (switch_on_main)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_BOOT_ON_FAST: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		!opt_loaded |-> CLK_SEL_FAST_O && !CLK_SEL_MAIN_O)
		else $error("cpu clock not on fast oscillator after reset");
	AST_FLASH_MODE: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		$rose(opt_loaded) |=>
		FLASH_HIGH_SPEED_O == (boot_clock_option[7:6] == clock_source_pkg::FLASH_HIGH_SPEED))
		else $error("flash mode output does not follow option byte");
	AST_FREQ_INIT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		$rose(opt_loaded) |=> FAST_OSC_MHZ_O ==
		clock_source_pkg::fast_osc_mhz($past(boot_clock_option[3]), $past(boot_clock_option[2:0])))
		else $error("initial fast oscillator frequency wrong");
	AST_DIV_RESERVED: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		rd_start && rd_div |=> HRDATA_O[31:3] == 29'h0000_0000)
		else $error("divider upper bits not zero");
	AST_DIV_LIMIT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		opt_loaded && wr_div && !new_in_range |=> $stable(fast_osc_divider))
		else $error("out of range divider code accepted");
	AST_DIV_TAKE: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		opt_loaded && wr_div && new_in_range |=> ##1 FAST_OSC_MHZ_O == $past(new_mhz, 2))
		else $error("divider write not reflected in frequency");
	AST_MODE_ONCE: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		clock_mode_written |=> $stable(clock_mode_ctrl))
		else $error("clock mode register changed after first write");
	AST_MAIN_RUNNING: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		CLK_SEL_MAIN_O |-> !main_halted && pin_mode)
		else $error("main clock selected while crystal halted");
	AST_FAST_KEPT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		CLK_SEL_FAST_O && wr_run |=> !fast_halted)
		else $error("fast oscillator halted while in use");
	AST_MAIN_KEPT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		CLK_SEL_MAIN_O && wr_run |=> !main_halted)
		else $error("crystal halted while in use");
	AST_SYS_STATUS: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		rd_start && rd_sys |=> HRDATA_O[5] == $past(sel_main))
		else $error("main source status bit does not show the selection");
	// a switch onto an unsettled crystal would clock the cpu from a stalled source
	AST_SETTLE_GATE: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		$rose(CLK_SEL_MAIN_O) |-> $past(main_ok))
		else $error("main clock enabled before crystal settled");
	AST_OPT_READONLY: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		opt_loaded |=> $stable(boot_clock_option))
		else $error("boot option changed after capture");

endmodule

/* File: inc/clock_source_pkg.sv */
// shared constants, types and helper functions of the clock source control block
package clock_source_pkg;

	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] IDX_BOOT_OPTION  = 32'h0000_00c2;
	localparam logic [31:0] IDX_FAST_DIV     = 32'h000f_00a8;
	localparam logic [31:0] IDX_CLOCK_MODE   = 32'h0000_00c4;
	localparam logic [31:0] IDX_SETTLE_SEL   = 32'h0000_00c5;
	localparam logic [31:0] IDX_OSC_RUN      = 32'h0000_00c6;
	localparam logic [31:0] IDX_SETTLE_STAT  = 32'h0000_00c7;
	localparam logic [31:0] IDX_SYS_CLOCK    = 32'h0000_00c8;

	localparam logic [31:0] ADDR_BOOT_OPTION = {IDX_BOOT_OPTION[29:0], 2'b00};
	localparam logic [31:0] ADDR_FAST_DIV    = {IDX_FAST_DIV[29:0], 2'b00};
	localparam logic [31:0] ADDR_CLOCK_MODE  = {IDX_CLOCK_MODE[29:0], 2'b00};
	localparam logic [31:0] ADDR_SETTLE_SEL  = {IDX_SETTLE_SEL[29:0], 2'b00};
	localparam logic [31:0] ADDR_OSC_RUN     = {IDX_OSC_RUN[29:0], 2'b00};
	localparam logic [31:0] ADDR_SETTLE_STAT = {IDX_SETTLE_STAT[29:0], 2'b00};
	localparam logic [31:0] ADDR_SYS_CLOCK   = {IDX_SYS_CLOCK[29:0], 2'b00};

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_CLOCK_MODE   = 8'h00;
	localparam logic [2:0]  RST_SETTLE_SEL   = 3'h7;
	localparam logic [7:0]  RST_OSC_RUN      = 8'hc0;
	localparam logic [2:0]  RST_FAST_DIV     = 3'h0;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned OPT_FLASH_HI     = 7;
	localparam int unsigned OPT_FLASH_LO     = 6;
	localparam int unsigned OPT_FREQ_TOP     = 3;
	localparam int unsigned CMC_EXT_CLOCK    = 7;
	localparam int unsigned CMC_PIN_MODE     = 6;
	localparam int unsigned CMC_GAIN         = 0;
	localparam int unsigned CSC_MAIN_HALT    = 7;
	localparam int unsigned CSC_SUB_HALT     = 6;
	localparam int unsigned CSC_FAST_HALT    = 0;
	localparam int unsigned CKC_SUB_SEL      = 6;

	// ----------------------------------------------------------------
	// codes and counts
	// ----------------------------------------------------------------
	localparam logic [1:0]  FLASH_LOW_SPEED  = 2'h2;
	localparam logic [1:0]  FLASH_HIGH_SPEED = 2'h3;
	localparam logic [5:0]  LOW_SPEED_MAX_MHZ = 6'h08;
	localparam logic [2:0]  HSIZE_BYTE       = 3'h0;
	localparam logic [2:0]  HSIZE_WORD       = 3'h2;
	localparam int unsigned SWITCH_GAP_CYCLES = 2;
	localparam int unsigned SETTLE_CNT_W     = 19;

	typedef enum logic [1:0] {SW_FAST, SW_GAP_MAIN, SW_MAIN, SW_GAP_FAST} switch_state_t;

	// frequency in MHz for a top bit and a three-bit code, zero when prohibited
	function automatic logic [5:0] fast_osc_mhz(input logic top, input logic [2:0] code);
		case ({top, code})
			4'h8:    fast_osc_mhz = 6'h20;
			4'h0:    fast_osc_mhz = 6'h18;
			4'h9:    fast_osc_mhz = 6'h10;
			4'h1:    fast_osc_mhz = 6'h0c;
			4'ha:    fast_osc_mhz = 6'h08;
			4'h2:    fast_osc_mhz = 6'h06;
			4'hb:    fast_osc_mhz = 6'h04;
			4'h3:    fast_osc_mhz = 6'h03;
			4'hc:    fast_osc_mhz = 6'h02;
			4'hd:    fast_osc_mhz = 6'h01;
			default: fast_osc_mhz = 6'h00;
		endcase
	endfunction

	// log2 of the crystal cycles behind status bit (7 - k)
	function automatic int unsigned settle_exp(input int unsigned k);
		case (k)
			0:       settle_exp = 8;
			1:       settle_exp = 9;
			2:       settle_exp = 10;
			3:       settle_exp = 11;
			4:       settle_exp = 13;
			5:       settle_exp = 15;
			6:       settle_exp = 17;
			default: settle_exp = 18;
		endcase
	endfunction

endpackage

/* File: src/settle_counter.sv */
// crystal stabilization counter and its thermometer status flags
`timescale 1ns/10ps
module settle_counter #(
	parameter int unsigned CNT_W = clock_source_pkg::SETTLE_CNT_W
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic       tick_i,
	output logic      [7:0] status_o
);

	logic [CNT_W-1:0] count;
	logic [7:0]       reached;
	wire              saturated = count[CNT_W-1];

	// ----------------------------------------------------------------
	// threshold compare
	// ----------------------------------------------------------------
	always_comb begin
		reached = 8'h00;
		for (int unsigned k = 0; k < 8; k++) begin
			reached[7-k] = (count >> clock_source_pkg::settle_exp(k)) != '0;
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	// counts crystal ticks only; a halted oscillator restarts from zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count    <= '0;
			status_o <= 8'h00;
		end else if (!run_i) begin
			count    <= '0;
			status_o <= 8'h00;
		end else begin
			count    <= (tick_i && !saturated) ? count + 1'b1 : count;
			status_o <= reached;
		end
	end

	AST_SETTLE_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i) !run_i |=> status_o == 8'h00)
		else $error("settle flags not cleared while oscillator halted");
	AST_SETTLE_ORDER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(status_o & ~{1'b1, status_o[7:1]}) == 8'h00)
		else $error("settle flags not set from bit 7 downward");

endmodule

/* File: src/clock_switch.sv */
// break-before-make selector between fast oscillator and main crystal clock
`timescale 1ns/10ps
module clock_switch #(
	parameter int unsigned GAP = clock_source_pkg::SWITCH_GAP_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic want_main_i,
	input  wire logic main_ok_i,
	input  wire logic fast_ok_i,
	output logic      sel_fast_o,
	output logic      sel_main_o,
	output logic      on_main_o
);

	localparam int unsigned GW = $clog2(GAP + 1);

	clock_source_pkg::switch_state_t state;
	clock_source_pkg::switch_state_t next_state;
	logic [GW-1:0]                   gap_cnt;
	wire                             gap_done = gap_cnt == GW'(GAP - 1);

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			clock_source_pkg::SW_FAST: begin
				if (want_main_i && main_ok_i) next_state = clock_source_pkg::SW_GAP_MAIN;
			end
			clock_source_pkg::SW_GAP_MAIN: begin
				if (gap_done) next_state = main_ok_i ? clock_source_pkg::SW_MAIN : clock_source_pkg::SW_FAST;
			end
			clock_source_pkg::SW_MAIN: begin
				if (!want_main_i && fast_ok_i) next_state = clock_source_pkg::SW_GAP_FAST;
			end
			default: begin
				if (gap_done) next_state = clock_source_pkg::SW_FAST;
			end
		endcase
	end

	assign on_main_o = state != clock_source_pkg::SW_FAST;

	// both enables low for GAP cycles, so no runt pulse can pass the gate
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state      <= clock_source_pkg::SW_FAST;
			gap_cnt    <= '0;
			sel_fast_o <= 1'b1;
			sel_main_o <= 1'b0;
		end else begin
			state      <= next_state;
			gap_cnt    <= (next_state == state && !gap_done) ? gap_cnt + 1'b1 : '0;
			sel_fast_o <= next_state == clock_source_pkg::SW_FAST;
			sel_main_o <= next_state == clock_source_pkg::SW_MAIN;
		end
	end

	AST_NO_OVERLAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) !(sel_fast_o && sel_main_o))
		else $error("both clock sources enabled at once");
	AST_GAP_MAIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(sel_fast_o) |-> !sel_main_o ##1 !sel_main_o)
		else $error("main clock enabled without a gap");
	AST_GAP_FAST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(sel_main_o) |-> !sel_fast_o ##1 !sel_fast_o)
		else $error("fast clock enabled without a gap");

endmodule

/* File: verification/main_clock_source_setup_tb.sv */
// self-checking bench of the clock source control block
`timescale 1ns/10ps
module main_clock_source_setup_tb;
	logic              clk = 0, rst_n = 0, hsel = 0, hwrite = 0, tick = 0;
	logic        [1:0] htrans = 0;
	logic       [31:0] haddr = 0, hwdata = 0;
	logic        [7:0] boot = 8'hc8;
	wire logic  [31:0] hrdata;
	wire logic   [5:0] mhz;
	wire logic         hready, hresp, fhs, fhalt, shalt, mhalt, pin, ext, gain, sfast, smain;
	int                n_errors = 0, checks = 0;
	logic       [31:0] r;
	logic        [5:0] f[8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h01, 6'h01};
	clock_source_ctrl dut_u (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
		.BOOT_OPTION_I(boot), .MAIN_XTAL_TICK_I(tick), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
		.HRESP_O(hresp), .FLASH_HIGH_SPEED_O(fhs), .FAST_OSC_MHZ_O(mhz), .FAST_OSC_HALT_O(fhalt),
		.SUB_OSC_HALT_O(shalt), .MAIN_OSC_HALT_O(mhalt), .MAIN_OSC_PIN_MODE_O(pin),
		.MAIN_EXT_CLOCK_SEL_O(ext), .MAIN_OSC_GAIN_O(gain), .CLK_SEL_FAST_O(sfast), .CLK_SEL_MAIN_O(smain));
	// ------------------------------------------------------------
	// bus and checking helpers
	// ------------------------------------------------------------
	initial forever #5 clk = ~clk;
	// crystal at half the core rate keeps the settle wait short
	always @(posedge clk) tick <= ~tick;
	always @(negedge clk) if (rst_n) check("both selects", sfast & smain, 0);
	initial begin
		#100000;
		n_errors++;
		complete_run;
	end
	task complete_run;
		if (n_errors == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0; hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		hsel <= 0;
		check("response", hresp, 0);
	endtask
	task do_reset(input logic [7:0] opt);
		rst_n <= 0; boot <= opt;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		repeat (3) @(posedge clk);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		check("fast sel", {sfast, smain, mhalt, fhalt}, 4'ha);
		check("flash hs", fhs, 1);
		check("mhz", mhz, 6'h20);
		bus(0, clock_source_pkg::ADDR_BOOT_OPTION, 0); check("option", r, 32'h0000_00c8);
		bus(1, clock_source_pkg::ADDR_OSC_RUN, 32'h0000_00c1);
		bus(0, clock_source_pkg::ADDR_OSC_RUN, 0); check("run ctrl", r, 32'h0000_00c0);
		bus(0, 32'h0000_0400, 0); check("unmapped", r, 0);
	endtask
	task t_div;
		for (int c = 0; c < 8; c++) begin
			bus(1, clock_source_pkg::ADDR_FAST_DIV, 32'hffff_fff8 | c);
			bus(0, clock_source_pkg::ADDR_FAST_DIV, 0);
			check("divider", r, (c > 5) ? 5 : c);
			check("div mhz", mhz, f[c]);
		end
	endtask
	task t_mode;
		bus(1, clock_source_pkg::ADDR_CLOCK_MODE, 32'h0000_0041);
		bus(1, clock_source_pkg::ADDR_CLOCK_MODE, 32'h0000_0080);
		bus(0, clock_source_pkg::ADDR_CLOCK_MODE, 0); check("mode", r, 32'h0000_0041);
		check("mode pins", {ext, pin, gain}, 3'h3);
	endtask
	task t_settle;
		bus(1, clock_source_pkg::ADDR_SETTLE_SEL, 0);
		bus(1, clock_source_pkg::ADDR_OSC_RUN, 32'h0000_0040);
		bus(0, clock_source_pkg::ADDR_SETTLE_STAT, 0); check("early stat", r, 0);
		check("main halt", mhalt, 0);
		check("sub halt", shalt, 1);
		for (int i = 0; i < 200 && r[7] !== 1'b1; i++) bus(0, clock_source_pkg::ADDR_SETTLE_STAT, 0);
		check("settle stat", r, 32'h0000_0080);
		check("early switch", smain, 0);
		bus(1, clock_source_pkg::ADDR_SYS_CLOCK, 32'h0000_0010);
		repeat (6) @(posedge clk);
		check("main sel", {sfast, smain}, 2'h1);
		bus(1, clock_source_pkg::ADDR_OSC_RUN, 32'h0000_00c1);
		bus(0, clock_source_pkg::ADDR_OSC_RUN, 0); check("halt on main", r, 32'h0000_0041);
		check("fast halt", {mhalt, fhalt}, 2'h1);
		bus(1, clock_source_pkg::ADDR_OSC_RUN, 32'h0000_0040);
		bus(0, clock_source_pkg::ADDR_SYS_CLOCK, 0); check("sys clock", r, 32'h0000_0030);
		bus(1, clock_source_pkg::ADDR_SYS_CLOCK, 0);
		repeat (6) @(posedge clk);
		check("back fast", {sfast, smain}, 2'h2);
	endtask
	task t_low;
		do_reset(8'h82);
		check("low mode", {fhs, mhz}, 7'h06);
		bus(1, clock_source_pkg::ADDR_FAST_DIV, 1);
		bus(1, clock_source_pkg::ADDR_FAST_DIV, 4);
		bus(0, clock_source_pkg::ADDR_FAST_DIV, 0); check("div kept", r, 2);
		bus(1, clock_source_pkg::ADDR_FAST_DIV, 3);
		bus(0, clock_source_pkg::ADDR_FAST_DIV, 0); check("low mhz", mhz, 6'h03);
	endtask
	initial begin
		do_reset(8'hc8);
		t_reset;
		t_div;
		t_mode;
		t_settle;
		t_low;
		complete_run;
	end
endmodule
